//--- core/nibble_bus_cfg.svh
// Constants for the nibble bus read target: field codes, counts and widths.
// Assumes inclusion by bare name from the package and the target module.
`ifndef NIBBLE_BUS_CFG_SVH
`define NIBBLE_BUS_CFG_SVH

// ---------------------------------------------------------------------------
// Field codes
// ---------------------------------------------------------------------------
`define NB_START_READ   4'hD
`define NB_SIZE_ONE     4'h0
`define NB_WAIT_SYNC    4'h5
`define NB_READY_SYNC   4'h0
`define NB_TURN_ONES    4'hF

// ---------------------------------------------------------------------------
// Counts and widths
// ---------------------------------------------------------------------------
`define NB_ADDR_LAST    3'h6
`define NB_WAIT_MIN     2'h1
`define NB_ADDR_ZERO    28'h000_0000
`define NB_FIFO_DEPTH   4
`define NB_FIFO_WIDTH   8

`endif

//--- core/nibble_bus_pkg.sv
// Types shared by the nibble bus read target, its property checks and its bench.
// Assumes the constants header is on the include path.
`include "nibble_bus_cfg.svh"

package nibble_bus_pkg;

	// -----------------------------------------------------------------------
	// Protocol states, one-hot
	// -----------------------------------------------------------------------
	typedef enum logic [11:0] {
		IDLE     = 12'h001,
		SELECT   = 12'h002,
		ADDRESS  = 12'h004,
		SIZE     = 12'h008,
		TURN_IN  = 12'h010,
		TURN_OWN = 12'h020,
		WAITING  = 12'h040,
		READY    = 12'h080,
		DATA_LO  = 12'h100,
		DATA_HI  = 12'h200,
		TURN_OUT = 12'h400,
		SKIP     = 12'h800
	} proto_state_t;

	// Memory fetch request towards the flash array.
	typedef struct packed {
		logic        valid;
		logic [27:0] address;
	} mem_request_t;

	// Registered drive of the nibble bus.
	typedef struct packed {
		logic [3:0] data;
		logic       enable_n;
	} nibble_drive_t;

endpackage

//--- core/nibble_bus_read_target.sv
// Read-cycle target of a 4-bit multiplexed host bus with a frame strobe,
// plus the small buffer that carries fetched bytes into the reply.
// Assumes clk is the bus clock shared with the host, so bus pins are already
// in this domain, and that the strap identifier is static after reset.
//
// What this block does
// - Information moves as 4-bit fields, some fields lasting several clocks.
// - Start code 1101 with frame strobe low opens a memory read.
// - Over a long strobe, only the final start code before release counts.
// - Select nibble must equal the strap identifier, else the cycle is ignored.
// - Seven address nibbles, most significant first, form a 28-bit address.
// - Size field 0000 asks one byte; only single bytes are supported.
// - Device takes the bus in second turnaround, syncs from the next clock; here it floats in both turnaround clocks and first drives the wait-sync.
// - Wait-sync 0101 for at least two clocks while data is not ready.
// - Ready-sync 0000 announces the low data nibble in the next clock.
// - Low data nibble follows ready-sync, then the high nibble.
// - Only the single-byte case is done; no further bytes follow.
// - After the last nibble the device drives ones, then floats.
// - Fields are sampled on the rising edge of their own clock.
// - Frame strobe low floats outputs and restarts the machine: select on a start code, else idle.
// - Any size other than 0000 resets the machine with no response.
`include "nibble_bus_cfg.svh"

// ---------------------------------------------------------------------------
// Buffer between the memory reply and the bus reply
// ---------------------------------------------------------------------------
module nibble_byte_fifo #(
	parameter int WIDTH = `NB_FIFO_WIDTH,
	parameter int DEPTH = `NB_FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             reset_n,
	// Filling side
	input  wire logic             inValid,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  inReady,
	// Draining side
	output logic                  outValid,
	output logic [WIDTH-1:0]      outData,
	input  wire logic             outReady
);

	localparam int PTR_W = $clog2(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [PTR_W-1:0] writePtr;
	logic [PTR_W-1:0] readPtr;
	logic [PTR_W:0]   count;
	logic             push;
	logic             pop;

	// Full and empty come straight from the occupancy count.
	assign inReady  = (count != (PTR_W+1)'(DEPTH));
	assign outValid = (count != '0);
	assign outData  = store[readPtr];
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	// Storage has no reset; only the count and the pointers guard what is read.
	always_ff @(posedge clk) begin
		if (push) begin
			store[writePtr] <= inData;
		end
	end

	// Pointers wrap at the depth, which must be a power of two.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			writePtr <= '0;
			readPtr  <= '0;
		end else begin
			if (push) begin
				writePtr <= writePtr + 1'b1;
			end
			if (pop) begin
				readPtr <= readPtr + 1'b1;
			end
		end
	end

	// Occupancy tracks simultaneous push and pop.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count <= '0;
		end else if (push && !pop) begin
			count <= count + 1'b1;
		end else if (pop && !push) begin
			count <= count - 1'b1;
		end
	end

endmodule

// ---------------------------------------------------------------------------
// Read target
// ---------------------------------------------------------------------------
module nibble_bus_read_target (
	// Clock and reset
	input  wire logic                         clk,
	input  wire logic                         reset_n,
	// Host bus, shared clock
	input  wire logic                         frame_strobe_n,
	input  wire logic [3:0]                   nibbleBusIn,
	output logic      [3:0]                   nibbleBusOut,
	output logic                              nibbleBusOe_n,
	// Strap
	input  wire logic [3:0]                   strap_identifier,
	// Memory fetch request, one-cycle pulse
	output nibble_bus_pkg::mem_request_t      memRequest,
	// Memory reply stream
	input  wire logic                         memReplyValid,
	input  wire logic [7:0]                   memReplyData,
	output logic                              memReplyReady
);

	nibble_bus_pkg::proto_state_t  state;
	nibble_bus_pkg::proto_state_t  next_state;
	nibble_bus_pkg::nibble_drive_t drive;
	nibble_bus_pkg::nibble_drive_t next_drive;
	logic [3:0]  strapId;
	logic        strapTaken;
	logic [27:0] address;
	logic [2:0]  addrCount;
	logic [1:0]  waitCount;
	logic [7:0]  dataByte;
	logic        fetchOpen;
	logic [2:0]  staleCount;
	logic        bufValid;
	logic [7:0]  bufData;
	logic        bufReady;
	logic        abortNow;
	logic        takeByte;
	logic        dropStale;

	// Drive the bus for the state the machine is about to enter.
	function automatic nibble_bus_pkg::nibble_drive_t driveFor(
		input nibble_bus_pkg::proto_state_t s,
		input logic [7:0]                   b
	);
		nibble_bus_pkg::nibble_drive_t d;
		d.data     = `NB_TURN_ONES;
		d.enable_n = 1'b0;
		case (s)
			nibble_bus_pkg::WAITING:  d.data = `NB_WAIT_SYNC;
			nibble_bus_pkg::READY:    d.data = `NB_READY_SYNC;
			nibble_bus_pkg::DATA_LO:  d.data = b[3:0];
			nibble_bus_pkg::DATA_HI:  d.data = b[7:4];
			nibble_bus_pkg::TURN_OUT: d.data = `NB_TURN_ONES;
			default:                  d.enable_n = 1'b1;
		endcase
		return d;
	endfunction

	// -----------------------------------------------------------------------
	// Strap capture
	// -----------------------------------------------------------------------

	// The strap is caught on the first edge after reset release, never by
	// the asynchronous reset itself.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			strapId    <= 4'h0;
			strapTaken <= 1'b0;
		end else if (!strapTaken) begin
			strapId    <= strap_identifier;
			strapTaken <= 1'b1;
		end
	end

	// -----------------------------------------------------------------------
	// Protocol machine
	// -----------------------------------------------------------------------

	// Strobe low aborts; data leaves the buffer only once older replies are gone.
	assign abortNow  = !frame_strobe_n;
	assign takeByte  = (state == nibble_bus_pkg::WAITING) && (waitCount == `NB_WAIT_MIN)
		&& bufValid && (staleCount == 3'h0);
	assign dropStale = bufValid && (staleCount != 3'h0);
	assign bufReady  = takeByte || dropStale;

	// Next state; the frame strobe overrides every field.
	always_comb begin
		next_state = state;
		if (abortNow) begin
			// Each low clock re-decides, so only the last start code counts.
			if (nibbleBusIn == `NB_START_READ) begin
				next_state = nibble_bus_pkg::SELECT;
			end else begin
				next_state = nibble_bus_pkg::IDLE;
			end
		end else begin
			case (state)
				nibble_bus_pkg::IDLE: next_state = nibble_bus_pkg::IDLE;
				nibble_bus_pkg::SELECT: begin
					if (nibbleBusIn == strapId) begin
						next_state = nibble_bus_pkg::ADDRESS;
					end else begin
						next_state = nibble_bus_pkg::SKIP;
					end
				end
				nibble_bus_pkg::ADDRESS: begin
					if (addrCount == `NB_ADDR_LAST) begin
						next_state = nibble_bus_pkg::SIZE;
					end
				end
				nibble_bus_pkg::SIZE: begin
					if (nibbleBusIn == `NB_SIZE_ONE) begin
						next_state = nibble_bus_pkg::TURN_IN;
					end else begin
						next_state = nibble_bus_pkg::IDLE;
					end
				end
				nibble_bus_pkg::TURN_IN:  next_state = nibble_bus_pkg::TURN_OWN;
				nibble_bus_pkg::TURN_OWN: next_state = nibble_bus_pkg::WAITING;
				nibble_bus_pkg::WAITING: begin
					if (takeByte) begin
						next_state = nibble_bus_pkg::READY;
					end
				end
				nibble_bus_pkg::READY:   next_state = nibble_bus_pkg::DATA_LO;
				nibble_bus_pkg::DATA_LO: next_state = nibble_bus_pkg::DATA_HI;
				nibble_bus_pkg::DATA_HI: next_state = nibble_bus_pkg::TURN_OUT;
				nibble_bus_pkg::TURN_OUT: next_state = nibble_bus_pkg::IDLE;
				nibble_bus_pkg::SKIP:    next_state = nibble_bus_pkg::SKIP;
				default:                 next_state = nibble_bus_pkg::IDLE;
			endcase
		end
	end

	// State register; every field is taken on the edge of its own clock.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= nibble_bus_pkg::IDLE;
		end else begin
			state <= next_state;
		end
	end

	// -----------------------------------------------------------------------
	// Address assembly
	// -----------------------------------------------------------------------

	// Shifting left puts the first nibble at the top of the address.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			address   <= `NB_ADDR_ZERO;
			addrCount <= 3'h0;
		end else if (state == nibble_bus_pkg::SELECT) begin
			addrCount <= 3'h0;
		end else if (state == nibble_bus_pkg::ADDRESS && !abortNow) begin
			address   <= {address[23:0], nibbleBusIn};
			addrCount <= addrCount + 3'h1;
		end
	end

	// -----------------------------------------------------------------------
	// Memory fetch and stale reply accounting
	// -----------------------------------------------------------------------

	// A fetch starts as soon as the size field proves valid, which leaves
	// four clocks from the request to the first possible ready-sync.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			memRequest.valid   <= 1'b0;
			memRequest.address <= `NB_ADDR_ZERO;
		end else begin
			memRequest.valid <= (state == nibble_bus_pkg::SIZE) && !abortNow
				&& (nibbleBusIn == `NB_SIZE_ONE);
			if (state == nibble_bus_pkg::SIZE) begin
				memRequest.address <= address;
			end
		end
	end

	// A fetch is open from its request until its byte is taken or abandoned.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fetchOpen <= 1'b0;
		end else if (memRequest.valid || takeByte || abortNow) begin
			fetchOpen <= memRequest.valid && !abortNow;
		end
	end

	// An abandoned fetch still returns a byte later; it is counted here and
	// thrown away so that the next read never sees an old value.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			staleCount <= 3'h0;
		end else begin
			case ({abortNow && (fetchOpen || memRequest.valid) && !takeByte, dropStale})
				2'b10:   staleCount <= staleCount + 3'h1;
				2'b01:   staleCount <= staleCount - 3'h1;
				default: staleCount <= staleCount;
			endcase
		end
	end

	// Byte to be sent, held through both data nibbles.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dataByte <= 8'h00;
		end else if (takeByte) begin
			dataByte <= bufData;
		end
	end

	// Wait-sync clocks counted so that at least two are always sent.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			waitCount <= 2'h0;
		end else if (state != nibble_bus_pkg::WAITING) begin
			waitCount <= 2'h0;
		end else if (waitCount != `NB_WAIT_MIN) begin
			waitCount <= waitCount + 2'h1;
		end
	end

	// -----------------------------------------------------------------------
	// Reply buffer
	// -----------------------------------------------------------------------

	nibble_byte_fifo #(
		.WIDTH (`NB_FIFO_WIDTH),
		.DEPTH (`NB_FIFO_DEPTH)
	) replyBuffer (
		.clk      (clk),
		.reset_n  (reset_n),
		.inValid  (memReplyValid),
		.inData   (memReplyData),
		.inReady  (memReplyReady),
		.outValid (bufValid),
		.outData  (bufData),
		.outReady (bufReady)
	);

	// -----------------------------------------------------------------------
	// Bus drive
	// -----------------------------------------------------------------------

	// Drive follows the state being entered, so the nibble is on the pins
	// for the whole clock of its field; abort floats from the next clock.
	always_comb begin
		if (abortNow) begin
			next_drive.data     = `NB_TURN_ONES;
			next_drive.enable_n = 1'b1;
		end else begin
			next_drive = driveFor(next_state, takeByte ? bufData : dataByte);
		end
	end

	// Drive register; floats from reset onward.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			drive.data     <= `NB_TURN_ONES;
			drive.enable_n <= 1'b1;
		end else begin
			drive <= next_drive;
		end
	end

	assign nibbleBusOut  = drive.data;
	assign nibbleBusOe_n = drive.enable_n;
endmodule

//--- verification/nibble_bus_read_target_properties.sv
// Concurrent checks of the nibble bus read target, seen from its ports.
// Assumes one clock domain and the asynchronous active-low reset.
module nibble_bus_read_target_properties (
	// Clock and reset
	input wire logic                         clk,
	input wire logic                         reset_n,
	// Host bus
	input wire logic                         frame_strobe_n,
	input wire logic [3:0]                   nibbleBusIn,
	input wire logic [3:0]                   nibbleBusOut,
	input wire logic                         nibbleBusOe_n,
	input wire logic [3:0]                   strap_identifier,
	// Memory fetch
	input wire nibble_bus_pkg::mem_request_t memRequest
);
	timeunit 1ns;
	timeprecision 1ps;

	// ---------------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	// Two driven wait-syncs open every reply.
	sequence s_open;
		nibbleBusOut == 4'h5 ##1 nibbleBusOut == 4'h5;
	endsequence
	// A ready-sync needs two driven wait-syncs before it, so a data nibble
	// of value zero is never taken for one.
	sequence s_ready;
		!nibbleBusOe_n && nibbleBusOut == 4'h0 && $past(nibbleBusOut) == 4'h5
			&& $past(nibbleBusOut, 2) == 4'h5 && !$past(nibbleBusOe_n, 2);
	endsequence
	property p_abort_float;
		!frame_strobe_n |=> nibbleBusOe_n;
	endproperty
	property p_sync_open;
		$fell(nibbleBusOe_n) && frame_strobe_n |-> $past(memRequest.valid, 2) ##0 s_open;
	endproperty
	property p_tail;
		s_ready ##1 frame_strobe_n [*3] |-> !nibbleBusOe_n && nibbleBusOut == 4'hF
			##1 nibbleBusOe_n;
	endproperty
	property p_req_start;
		memRequest.valid |-> $past(nibbleBusIn, 10) == 4'hD && !$past(frame_strobe_n, 10)
			&& $past(frame_strobe_n, 9);
	endproperty
	property p_req_select;
		memRequest.valid |-> $past(nibbleBusIn, 9) == strap_identifier;
	endproperty
	property p_req_address;
		memRequest.valid |-> memRequest.address == {$past(nibbleBusIn, 8),
			$past(nibbleBusIn, 7), $past(nibbleBusIn, 6), $past(nibbleBusIn, 5),
			$past(nibbleBusIn, 4), $past(nibbleBusIn, 3), $past(nibbleBusIn, 2)};
	endproperty
	property p_req_size;
		memRequest.valid |-> $past(nibbleBusIn) == 4'h0 && $past(frame_strobe_n);
	endproperty
	property p_req_pulse;
		memRequest.valid |=> (!memRequest.valid) [*8];
	endproperty

	a_abort_float: assert property (p_abort_float)
		else $error("bus driven after frame strobe low");
	a_sync_open: assert property (p_sync_open)
		else $error("reply does not open with two wait-syncs");
	a_tail: assert property (p_tail)
		else $error("no ones then float after the data");
	a_req_start: assert property (p_req_start)
		else $error("fetch without a final start code");
	a_req_select: assert property (p_req_select)
		else $error("fetch for another select value");
	a_req_address: assert property (p_req_address)
		else $error("fetch address mismatch");
	a_req_size: assert property (p_req_size)
		else $error("fetch with a bad size field");
	a_req_pulse: assert property (p_req_pulse)
		else $error("more than one fetch per cycle");
endmodule

bind nibble_bus_read_target nibble_bus_read_target_properties i_props (
	.clk(clk),
	.reset_n(reset_n),
	.frame_strobe_n(frame_strobe_n),
	.nibbleBusIn(nibbleBusIn),
	.nibbleBusOut(nibbleBusOut),
	.nibbleBusOe_n(nibbleBusOe_n),
	.strap_identifier(strap_identifier),
	.memRequest(memRequest)
);

//--- verification/host_chipset_model.sv
// Host side of the nibble bus: frames read cycles and collects replies.
// Assumes the bench calls its tasks and resolves nothing else on the wire.
module host_chipset_model (
	// Clock and device drive
	input wire logic       clk,
	input wire logic [3:0] devOut,
	input wire logic       devOe_n,
	// Host drive and wire level
	output logic           frame_strobe_n,
	output logic [3:0]     busWire
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] hostData = 4'hF;
	logic       hostOe = 1'b0;
	logic [3:0] lastWire = 4'hF;

	// ---------------------------------------------------------------------
	// Wire and fields
	// ---------------------------------------------------------------------
	initial frame_strobe_n = 1'b1;
	// No pull-up exists, so a released wire shows the inverse of its last level.
	always_comb begin
		if (devOe_n === 1'b0)
			busWire = devOut;
		else if (hostOe)
			busWire = hostData;
		else
			busWire = ~lastWire;
	end
	// Last wire level, kept for the floating pattern.
	always @(posedge clk) lastWire <= busWire;

	// One field for one clock; each field is taken at the edge ending it.
	task automatic field(input logic frameLow, input logic [3:0] v);
		@(posedge clk);
		frame_strobe_n <= !frameLow;
		hostData <= v;
		hostOe <= 1'b1;
	endtask
	// Two start clocks, select, address, size, then the host turnaround.
	task automatic header(input logic [3:0] s0, s1, id, input logic [27:0] a,
			input logic [3:0] sz);
		field(1'b1, s0);
		field(1'b1, s1);
		field(1'b0, id);
		for (int i = 6; i >= 0; i--)
			field(1'b0, a[i*4 +: 4]);
		field(1'b0, sz);
		field(1'b0, 4'hF);
		@(posedge clk);
		hostOe <= 1'b0;
	endtask
	// Frame strobe low for one clock while the bus is left to the device.
	task automatic abort();
		@(posedge clk);
		frame_strobe_n <= 1'b0;
		@(posedge clk);
		frame_strobe_n <= 1'b1;
	endtask
	// Wait-syncs, ready-sync, both nibbles, ones, float.
	task automatic reply(output logic [7:0] b, output int waits, output logic ok);
		logic [3:0] v;
		waits = 0;
		@(negedge clk);
		ok = devOe_n === 1'b1;
		do begin
			@(negedge clk);
			v = busWire;
			waits++;
		end while (v === 4'h5 && waits < 40);
		waits--;
		ok &= v === 4'h0 && devOe_n === 1'b0;
		@(negedge clk);
		b[3:0] = busWire;
		@(negedge clk);
		b[7:4] = busWire;
		@(negedge clk);
		ok &= busWire === 4'hF && devOe_n === 1'b0;
		@(negedge clk);
		ok &= devOe_n === 1'b1;
	endtask
	// The device must leave the wire alone for ten clocks.
	task automatic silent(output logic ok);
		ok = 1'b1;
		repeat (10) begin
			@(negedge clk);
			ok &= devOe_n === 1'b1;
		end
	endtask
endmodule

//--- verification/test_nibble_bus_read_target.sv
// Self-checking bench for the nibble bus read target.
// Assumes the host model and a behavioural memory stand around the design.
module test_nibble_bus_read_target;
	timeunit 1ns;
	timeprecision 1ps;
	logic                         clk = 1'b0;
	logic                         reset_n = 1'b0;
	logic                         frame_strobe_n;
	logic [3:0]                   busWire;
	logic [3:0]                   nibbleBusOut;
	logic                         nibbleBusOe_n;
	logic [3:0]                   strap = 4'hA;
	nibble_bus_pkg::mem_request_t memRequest;
	logic                         memReplyValid = 1'b0;
	logic [7:0]                   memReplyData = 8'h00;
	logic                         memReplyReady;
	logic [27:0]                  reqAddr = 28'h000_0000;
	logic                         pending = 1'b0;
	int                           memLatency = 0;
	int                           countdown = 0;
	int                           cycles = 0;
	int                           nFail = 0;
	int                           samplesChecked = 0;

	// ---------------------------------------------------------------------
	// Design, host and memory
	// ---------------------------------------------------------------------
	nibble_bus_read_target i_dut (
		.clk(clk),
		.reset_n(reset_n),
		.frame_strobe_n(frame_strobe_n),
		.nibbleBusIn(busWire),
		.nibbleBusOut(nibbleBusOut),
		.nibbleBusOe_n(nibbleBusOe_n),
		.strap_identifier(strap),
		.memRequest(memRequest),
		.memReplyValid(memReplyValid),
		.memReplyData(memReplyData),
		.memReplyReady(memReplyReady)
	);
	host_chipset_model i_host (
		.clk(clk),
		.devOut(nibbleBusOut),
		.devOe_n(nibbleBusOe_n),
		.frame_strobe_n(frame_strobe_n),
		.busWire(busWire)
	);
	always #2.5 clk = ~clk;
	// Memory content is a simple function of the address.
	function automatic logic [7:0] byteOf(input logic [27:0] a);
		return a[7:0] + a[27:20] + 8'h3C;
	endfunction
	// Memory answers after memLatency clocks and holds the byte until taken.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pending <= 1'b0;
			memReplyValid <= 1'b0;
		end else if (memRequest.valid === 1'b1) begin
			reqAddr <= memRequest.address;
			countdown <= memLatency;
			pending <= 1'b1;
		end else if (pending && countdown > 0)
			countdown <= countdown - 1;
		else if (pending && !memReplyValid) begin
			memReplyValid <= 1'b1;
			memReplyData <= byteOf(reqAddr);
		end else if (memReplyValid && memReplyReady === 1'b1) begin
			memReplyValid <= 1'b0;
			pending <= 1'b0;
		end
	end

	// ---------------------------------------------------------------------
	// Checks and scenarios
	// ---------------------------------------------------------------------
	task automatic print_verdict();
		if (nFail == 0 && samplesChecked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check_byte(input string what, input logic [7:0] exp, got);
		samplesChecked++;
		if (got !== exp) begin
			nFail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic check_bit(input string what, input logic got);
		check_byte(what, 8'h01, {7'h00, got});
	endtask
	task automatic read_check(input logic [27:0] a, input logic [3:0] s0, input int lat,
			input logic fast);
		logic [7:0] b;
		int         w;
		logic       ok;
		memLatency = lat;
		i_host.header(s0, 4'hD, strap, a, 4'h0);
		i_host.reply(b, w, ok);
		check_byte("read byte", byteOf(a), b);
		check_bit("reply framing", ok);
		check_bit("wait syncs", fast ? w == 2 : w > 2);
	endtask
	task automatic silent_check(input logic [3:0] s0, s1, id, sz);
		logic ok;
		i_host.header(s0, s1, id, 28'h055_AA55, sz);
		i_host.silent(ok);
		check_bit("no drive", ok);
	endtask
	// Back-to-back reads at boundary addresses, then a stalling memory.
	task automatic t_reads();
		read_check(28'h123_4567, 4'hD, 0, 1'b1);
		read_check(28'hFFF_FFFF, 4'hD, 0, 1'b1);
		read_check(28'h800_0010, 4'hD, 0, 1'b1);
		read_check(28'h0C0_FFEE, 4'hD, 6, 1'b0);
	endtask
	// Only the start code in the last low clock counts.
	task automatic t_last_start();
		silent_check(4'hD, 4'hC, strap, 4'h0);
		read_check(28'h246_8ACE, 4'hC, 0, 1'b1);
	endtask
	// Foreign select and two bad sizes (0001, 1111) are ignored; the next read still works.
	task automatic t_refused();
		logic [3:0] sizes [2] = '{4'h1, 4'hF};
		silent_check(4'hD, 4'hD, ~strap, 4'h0);
		foreach (sizes[i])
			silent_check(4'hD, 4'hD, strap, sizes[i]);
		read_check(28'h135_79BD, 4'hD, 0, 1'b1);
	endtask
	// Abort during the wait-syncs; the late byte must not leak into the next read.
	task automatic t_abort();
		memLatency = 3;
		i_host.header(4'hD, 4'hD, strap, 28'h0F0_0F0F, 4'h0);
		i_host.abort();
		@(negedge clk);
		check_bit("float on abort", nibbleBusOe_n);
		read_check(28'h111_2222, 4'hD, 0, 1'b1);
	endtask
	// Abort in the host turnaround, on the very clock the fetch goes out.
	task automatic t_abort_turn();
		memLatency = 2;
		for (int i = 0; i < 11; i++)
			i_host.field(i < 2, (i < 2) ? 4'hD : (i == 2) ? strap : 4'h0);
		i_host.field(1'b1, 4'hF);
		i_host.abort();
		@(negedge clk);
		check_bit("float on turn abort", nibbleBusOe_n);
		read_check(28'h0DD_0042, 4'hD, 0, 1'b1);
	endtask
	// Reset in mid-reply floats the bus and empties the buffer.
	task automatic t_reset();
		i_host.header(4'hD, 4'hD, strap, 28'h0AB_CDEF, 4'h0);
		@(posedge clk);
		reset_n <= 1'b0;
		@(negedge clk);
		check_bit("reset float", nibbleBusOe_n);
		check_bit("reset ready", memReplyReady);
		check_bit("reset fetch", !memRequest.valid);
		@(posedge clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge clk);
		read_check(28'h0AB_CDEF, 4'hD, 0, 1'b1);
	endtask

	// Cuts a hang short; the run needs well under a thousand clocks.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			nFail++;
			print_verdict();
		end
	end
	// Main sequence.
	initial begin
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_reads();
		t_last_start();
		t_refused();
		t_abort();
		t_abort_turn();
		t_reset();
		print_verdict();
	end
endmodule
